//--- cfl_pkg.sv
// Shared constants for the configuration lock control block
package cfl_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  // Byte offsets of the registers in this block
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] SEL_BASE = 8'h10;
  localparam logic [7:0] DIS_BASE = 8'h20;
  localparam int unsigned SEL_COUNT = 4;
  localparam int unsigned DIS_COUNT = 2;
  // Field positions
  localparam int unsigned PIN_LOCK_BIT = 13;
  localparam int unsigned MOD_LOCK_BIT = 12;
  localparam int unsigned DBG_EN_BIT = 3;
  localparam int unsigned TDO_USE_BIT = 0;
  // Read-only pattern of the unimplemented bits 2-1
  localparam logic [31:0] CFG_ONES = 32'h0000_0006;
  localparam logic PIN_LOCK_RST = 1'b0;
  localparam logic MOD_LOCK_RST = 1'b0;
  localparam logic DBG_EN_RST = 1'b1;
  localparam logic TDO_USE_RST = 1'b1;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED = 32'h0000_0000;
endpackage

//--- cfl_bus_if.sv
// Lock-gated write path and read path between the main block and the protected register file
`timescale 1ns/1ps
`default_nettype none
interface cfl_bus_if;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [7:0] raddr;
  logic [31:0] rdata;
  modport ctl (output wr, output addr, output wdata, output raddr, input rdata);
  modport bank (input wr, input addr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- cfl_reg_bank.sv
// Bank of word registers whose writes are gated by the caller
`timescale 1ns/1ps
`default_nettype none
module cfl_reg_bank #(
  parameter int unsigned COUNT = 4,
  parameter logic [7:0] BASE = 8'h10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  cfl_bus_if.bank bus,
  output logic [COUNT*32-1:0] regs_flat
);
  logic [31:0] mem [COUNT];

  function automatic logic hit(input logic [7:0] a, input int unsigned i);
    hit = (a == 8'(BASE + 8'(i * 4)));
  endfunction

  for (genvar i = 0; i < COUNT; i++) begin : g_reg
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        mem[i] <= cfl_pkg::REG_RST;
      end else if (bus.wr && hit(bus.addr, i)) begin
        mem[i] <= bus.wdata;
      end
    end
    assign regs_flat[i*32 +: 32] = mem[i];
  end

  always_comb begin
    bus.rdata = cfl_pkg::UNMAPPED;
    for (int i = 0; i < COUNT; i++) begin
      if (hit(bus.raddr, i)) begin
        bus.rdata = mem[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- cfl_top.sv
// Configuration lock control register with lock-guarded pin-select and module-disable banks
// What this block does
// - While the pin-select lock is set every write to the pin-select registers is dropped.
// - While the module-disable lock is set every write to the module-disable registers is dropped.
// - Software must unlock first, and lock bit changes without the unlock are ignored.
// - The debug port enable bit is read/write, resets to one and enables the debug port.
// - The TDO-use bit is read/write, resets to one and makes two-wire debug drive TDO.
// - Bits 31-14 and 11-4 read zero, bits 2-1 read one, and writes to them do nothing.
`timescale 1ns/1ps
`default_nettype none
module cfl_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic unlocked,
  output logic [31:0] rdata,
  output logic debug_port_enable,
  output logic two_wire_tdo_use,
  output logic pin_select_lock,
  output logic module_disable_lock,
  output logic [cfl_pkg::SEL_COUNT*32-1:0] pin_select_regs,
  output logic [cfl_pkg::DIS_COUNT*32-1:0] module_disable_regs
);
  ////////////////////////////////////////////////////////////////////////
  cfl_bus_if sel_bus ();
  cfl_bus_if dis_bus ();
  logic cfg_wr;
  logic unlocked_s1;
  logic unlocked_s2;
  logic [cfl_pkg::SEL_COUNT*32-1:0] sel_q;
  logic [cfl_pkg::DIS_COUNT*32-1:0] dis_q;
  logic [31:0] next_rdata;

  // Read-back bits that hold no state; the rest must follow the flops
  localparam logic [31:0] FIXED_MASK = ~((32'h1 << cfl_pkg::PIN_LOCK_BIT)
    | (32'h1 << cfl_pkg::MOD_LOCK_BIT) | (32'h1 << cfl_pkg::DBG_EN_BIT)
    | (32'h1 << cfl_pkg::TDO_USE_BIT));

  // Config register select, shared by the write, read and check paths
  function automatic logic is_cfg(input logic [7:0] a);
    return a == cfl_pkg::CFG_OFFSET;
  endfunction

  // The unlock state comes from another controller; treat it as asynchronous
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      unlocked_s1 <= 1'b0;
      unlocked_s2 <= 1'b0;
    end else begin
      unlocked_s1 <= unlocked;
      unlocked_s2 <= unlocked_s1;
    end
  end

  assign cfg_wr = wr_en && is_cfg(addr);

  ////////////////////////////////////////////////////////////////////////
  // Lock bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_select_lock <= cfl_pkg::PIN_LOCK_RST;
      module_disable_lock <= cfl_pkg::MOD_LOCK_RST;
    end else if (cfg_wr && unlocked_s2) begin
      pin_select_lock <= wdata[cfl_pkg::PIN_LOCK_BIT];
      module_disable_lock <= wdata[cfl_pkg::MOD_LOCK_BIT];
    end
  end

  // Debug controls need no unlock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      debug_port_enable <= cfl_pkg::DBG_EN_RST;
      two_wire_tdo_use <= cfl_pkg::TDO_USE_RST;
    end else if (cfg_wr) begin
      debug_port_enable <= wdata[cfl_pkg::DBG_EN_BIT];
      two_wire_tdo_use <= wdata[cfl_pkg::TDO_USE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protected banks; the lock gates the write strobe itself
  assign sel_bus.wr = wr_en && !pin_select_lock;
  assign sel_bus.addr = addr;
  assign sel_bus.wdata = wdata;
  assign sel_bus.raddr = addr;
  assign dis_bus.wr = wr_en && !module_disable_lock;
  assign dis_bus.addr = addr;
  assign dis_bus.wdata = wdata;
  assign dis_bus.raddr = addr;

  cfl_reg_bank #(
    .COUNT(cfl_pkg::SEL_COUNT),
    .BASE(cfl_pkg::SEL_BASE)
  ) u_sel (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .bus(sel_bus.bank),
    .regs_flat(sel_q)
  );

  cfl_reg_bank #(
    .COUNT(cfl_pkg::DIS_COUNT),
    .BASE(cfl_pkg::DIS_BASE)
  ) u_dis (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .bus(dis_bus.bank),
    .regs_flat(dis_q)
  );

  // Registered copies keep every output straight from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_select_regs <= '0;
      module_disable_regs <= '0;
    end else begin
      pin_select_regs <= sel_q;
      module_disable_regs <= dis_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    next_rdata = cfl_pkg::UNMAPPED;
    if (is_cfg(addr)) begin
      next_rdata = cfl_pkg::CFG_ONES;
      next_rdata[cfl_pkg::PIN_LOCK_BIT] = pin_select_lock;
      next_rdata[cfl_pkg::MOD_LOCK_BIT] = module_disable_lock;
      next_rdata[cfl_pkg::DBG_EN_BIT] = debug_port_enable;
      next_rdata[cfl_pkg::TDO_USE_BIT] = two_wire_tdo_use;
    end else begin
      next_rdata = sel_bus.rdata | dis_bus.rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= cfl_pkg::UNMAPPED;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= cfl_pkg::UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // Lock bits
  a_lock_needs_unlock: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !unlocked_s2 |=> $stable(pin_select_lock) && $stable(module_disable_lock))
    else $error("lock bit changed without unlock");
  a_lock_unlock_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_wr && unlocked_s2 |=> pin_select_lock == $past(wdata[cfl_pkg::PIN_LOCK_BIT]))
    else $error("unlocked lock write not taken");
  a_mod_lock_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_wr && unlocked_s2 |=> module_disable_lock == $past(wdata[cfl_pkg::MOD_LOCK_BIT]))
    else $error("unlocked module lock write not taken");

  // Protected banks
  a_pin_sel_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pin_select_lock && $past(pin_select_lock) |=> $stable(sel_q))
    else $error("pin-select bank written while locked");
  a_pin_sel_open: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !pin_select_lock && wr_en && addr == cfl_pkg::SEL_BASE |=> sel_q[31:0] == $past(wdata))
    else $error("pin-select write lost while open");
  a_mod_dis_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    module_disable_lock && $past(module_disable_lock) |=> $stable(dis_q))
    else $error("module-disable bank written while locked");
  a_mod_dis_open: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !module_disable_lock && wr_en && addr == cfl_pkg::DIS_BASE
    |=> dis_q[31:0] == $past(wdata))
    else $error("module-disable write lost while open");
  a_bank_copy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> pin_select_regs == $past(sel_q) && module_disable_regs == $past(dis_q))
    else $error("bank outputs do not follow the banks");

  // Debug controls
  a_debug_en_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_wr |=> debug_port_enable == $past(wdata[cfl_pkg::DBG_EN_BIT]))
    else $error("debug enable not written");
  a_tdo_use_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_wr |=> two_wire_tdo_use == $past(wdata[cfl_pkg::TDO_USE_BIT]))
    else $error("tdo use not written");
  a_debug_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !cfg_wr |=> $stable(debug_port_enable) && $stable(two_wire_tdo_use))
    else $error("debug control changed without a write");

  // Read path
  a_cfg_fixed_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_en && is_cfg(addr) |=> (rdata & FIXED_MASK) == cfl_pkg::CFG_ONES)
    else $error("fixed bits read wrong");
  a_cfg_read_debug: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_en && is_cfg(addr) |=> rdata[cfl_pkg::DBG_EN_BIT] == $past(debug_port_enable)
    && rdata[cfl_pkg::TDO_USE_BIT] == $past(two_wire_tdo_use))
    else $error("debug bits read back wrong");
  a_cfg_read_locks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_en && is_cfg(addr) |=> rdata[cfl_pkg::PIN_LOCK_BIT] == $past(pin_select_lock)
    && rdata[cfl_pkg::MOD_LOCK_BIT] == $past(module_disable_lock))
    else $error("lock bits read back wrong");
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !rd_en |=> rdata == cfl_pkg::UNMAPPED)
    else $error("read data stood past its cycle");

  // No disable here: it checks what reset leaves behind
  a_reset_values: assert property (@(posedge ref_clk)
    $past(sys_rst) |-> debug_port_enable && two_wire_tdo_use && !pin_select_lock
    && !module_disable_lock && rdata == cfl_pkg::UNMAPPED)
    else $error("reset values wrong");

  c_lock_set: cover property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_wr && unlocked_s2 && wdata[cfl_pkg::PIN_LOCK_BIT]);
  c_lock_blocked: cover property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_wr && !unlocked_s2 && wdata[cfl_pkg::MOD_LOCK_BIT]);
  c_sel_locked_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
    pin_select_lock && wr_en && addr == cfl_pkg::SEL_BASE);
  c_dis_locked_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
    module_disable_lock && wr_en && addr == cfl_pkg::DIS_BASE);
  c_cfg_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
    rd_en && is_cfg(addr));
endmodule
`default_nettype wire

//--- config_lock_control_test.sv
// Self-checking testbench for the configuration lock control block
`timescale 1ns/1ps
`default_nettype none
module config_lock_control_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic unlocked = 1'b0;
  logic [31:0] rdata;
  logic dbg;
  logic tdo;
  logic pin_lk;
  logic mod_lk;
  logic [cfl_pkg::SEL_COUNT*32-1:0] sel_regs;
  logic [cfl_pkg::DIS_COUNT*32-1:0] dis_regs;
  int errors = 0;
  int checks_done = 0;

  always #10 ref_clk = ~ref_clk;

  cfl_top dut_u (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .unlocked(unlocked),
    .rdata(rdata),
    .debug_port_enable(dbg),
    .two_wire_tdo_use(tdo),
    .pin_select_lock(pin_lk),
    .module_disable_lock(mod_lk),
    .pin_select_regs(sel_regs),
    .module_disable_regs(dis_regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask

  // Unlock input passes a two-flop synchroniser, so wait three edges
  task automatic set_unlock(input logic v);
    @(posedge ref_clk);
    unlocked <= v;
    repeat (3) @(posedge ref_clk);
  endtask

  // Bank outputs trail the bank by one cycle
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [31:0] outs;
    return {28'h0000000, pin_lk, mod_lk, dbg, tdo};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk("cfg reset", 8'h00, 32'h0000_000f);
    chk("outs reset", outs(), 32'h0000_0003);
  endtask

  task automatic t_cfg_bits;
    wr(8'h00, 32'hffff_ffff);
    rd_chk("cfg all ones", 8'h00, 32'h0000_000f);
    wr(8'h00, 32'h0000_0000);
    rd_chk("cfg zero", 8'h00, 32'h0000_0006);
    chk("outs cleared", outs(), 32'h0000_0000);
    wr(8'h00, 32'h0000_0009);
    #1;
    chk("outs set", outs(), 32'h0000_0003);
  endtask

  task automatic t_open_banks;
    wr(8'h1c, 32'ha5a5_0001);
    wr(8'h24, 32'h5a5a_0002);
    settle();
    chk("sel word3", sel_regs[127:96], 32'ha5a5_0001);
    chk("dis word1", dis_regs[63:32], 32'h5a5a_0002);
    rd_chk("sel read", 8'h1c, 32'ha5a5_0001);
    wr(8'h84, 32'hffff_ffff);
    rd_chk("unmapped", 8'h84, 32'h0000_0000);
  endtask

  // Locks set under unlock, then every write to the banks must bounce
  task automatic t_locked;
    set_unlock(1'b1);
    wr(8'h00, 32'h0000_3000);
    set_unlock(1'b0);
    rd_chk("cfg locked", 8'h00, 32'h0000_3006);
    chk("outs locked", outs(), 32'h0000_000c);
    wr(8'h1c, 32'h1111_1111);
    wr(8'h24, 32'h2222_2222);
    wr(8'h00, 32'h0000_0009);
    settle();
    chk("sel held", sel_regs[127:96], 32'ha5a5_0001);
    chk("dis held", dis_regs[63:32], 32'h5a5a_0002);
    rd_chk("lock kept", 8'h00, 32'h0000_300f);
    set_unlock(1'b1);
    wr(8'h00, 32'h0000_0009);
    set_unlock(1'b0);
    wr(8'h10, 32'h3333_3333);
    settle();
    chk("sel reopened", sel_regs[31:0], 32'h3333_3333);
    chk("outs unlocked", outs(), 32'h0000_0003);
  endtask

  // One lock at a time: only its own bank bounces
  task automatic t_single_locks;
    set_unlock(1'b1);
    wr(8'h00, 32'h0000_2009);
    set_unlock(1'b0);
    wr(8'h14, 32'h4444_4444);
    wr(8'h20, 32'h5555_5555);
    settle();
    chk("sel pin locked", sel_regs[63:32], 32'h0000_0000);
    chk("dis pin locked", dis_regs[31:0], 32'h5555_5555);
    set_unlock(1'b1);
    wr(8'h00, 32'h0000_1009);
    set_unlock(1'b0);
    rd_chk("cfg mod lock", 8'h00, 32'h0000_100f);
    @(posedge ref_clk);
    #1;
    chk("rdata idle", rdata, 32'h0000_0000);
    wr(8'h14, 32'h6666_6666);
    wr(8'h20, 32'h7777_7777);
    settle();
    chk("sel mod locked", sel_regs[63:32], 32'h6666_6666);
    chk("dis mod locked", dis_regs[31:0], 32'h5555_5555);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_cfg_bits();
    t_open_banks();
    t_locked();
    t_single_locks();
    close_out();
  end

  // Cuts a hang short
  initial begin
    #200000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
